// ### common/stc_pkg.sv
// package with register map, field layout and constants of the timer core
package stc_pkg;
  localparam int unsigned ADDR_W = 4;
  // register byte addresses
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_GATE = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CNT_LO = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CNT_HI = 4'hC;
  // timer_control_reg fields
  localparam int unsigned CTRL_ON = 0;
  localparam int unsigned CTRL_SYNC_DIS = 2;
  localparam int unsigned CTRL_OSC_EN = 3;
  localparam int unsigned CTRL_PS_LO = 4;
  localparam int unsigned CTRL_CS_LO = 6;
  // gate_control_reg fields
  localparam int unsigned GATE_EN = 7;
  localparam int unsigned GATE_OVF = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // clock source codes
  typedef enum logic [1:0]
  {
    STC_SRC_INSTR = 2'h0,
    STC_SRC_SYS = 2'h1,
    STC_SRC_EXT = 2'h2,
    STC_SRC_CAP = 2'h3
  } stc_src_t;
endpackage : stc_pkg

// ### common/stc_edge_if.sv
`timescale 1ns/1ps
// interface carrying the external-clock edge detector signals
interface stc_edge_if;
  logic clk_in;
  logic sync_dis;
  logic arm_clr;
  logic rise;
  modport det (input clk_in, input sync_dis, input arm_clr, output rise);
  modport core (output clk_in, output sync_dis, output arm_clr, input rise);
endinterface : stc_edge_if

// ### src/stc_edge_det.sv
`timescale 1ns/1ps
// rising-edge detector for external clocks, needs a falling edge before first rise
module stc_edge_det
(
  input wire logic aclk,
  input wire logic aresetn,
  stc_edge_if.det e
);
  import stc_pkg::*;
  logic s1_q, s1_d, s2_q, s2_d, prev_q, prev_d, armed_q, armed_d;
  logic lvl;
  // optional two-stage synchroniser; bypass samples the pin directly
  always_comb
  begin
    s1_d = e.clk_in;
    s2_d = s1_q;
    lvl = e.sync_dis ? e.clk_in : s2_q; // [R7] [R11]
    prev_d = lvl;
    armed_d = armed_q;
    if (e.arm_clr)
    begin
      armed_d = 1'b0; // [R8]
    end
    else if (prev_q && !lvl)
    begin
      armed_d = 1'b1; // [R8]
    end
    e.rise = armed_q && !prev_q && lvl && !e.arm_clr; // [R6]
  end
  // register stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      prev_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      prev_q <= prev_d;
      armed_q <= armed_d;
    end
  end
endmodule : stc_edge_det

// ### src/stc_timer.sv
`timescale 1ns/1ps
// sixteen-bit timer/counter core with an AXI4-Lite register slave
// Notes on behaviour
// [R1] 16-bit up-counter seen as low and high byte; byte writes replace live count
// [R2] counts only when on; gate enable set means gate permit must also be high
// [R3] source field and oscillator enable choose system, instruction, cap, pin or crystal
// [R4] instruction clock source advances once per four system cycles, via prescaler
// [R5] system clock source advances every system cycle
// [R6] external sources increment on rising edges
// [R7] external clock synchronised or used directly, software choice
// [R8] after enable, byte write or disable, a falling edge must precede counting
// [R9] prescaler divides chosen clock by 1, 2, 4 or 8
// [R10] prescaler hidden from software and cleared by any count byte write
// [R11] sync disable bit makes external counting unsynchronised; counting continues
// [R12] rollover FFFFh to 0000h sets overflow flag
// [R13] prescale codes 00,01,10,11 mean divide by 1,2,4,8
// [R14] single gate permit input honoured only with gate enable set
module stc_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_clock_pin,
  input wire logic crystal_input_pin,
  input wire logic cap_sense_oscillator,
  input wire logic gate_permit,
  output logic overflow_pulse
);
  import stc_pkg::*;

  stc_edge_if ext ();
  stc_edge_det u_edge (.aclk(aclk), .aresetn(aresetn), .e(ext));

  logic [7:0] ctrl_q, ctrl_d, gate_q, gate_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0] pre_q, pre_d;
  logic [1:0] idiv_q, idiv_d;
  logic on_q, on_d;
  logic ovf_q, ovf_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic aw_have_q, aw_have_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic w_have_q, w_have_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic do_write, wr_lo, wr_hi;
  logic running, tick, pre_out;
  logic [2:0] pre_mask;
  stc_src_t src;
  logic osc_en;

  // write channels: each address and data taken independently, response follows both
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign overflow_pulse = ovf_q;

  // byte writes to the count registers
  assign wr_lo = do_write && (awaddr_q == OFF_CNT_LO) && wstrb_q[0];
  assign wr_hi = do_write && (awaddr_q == OFF_CNT_HI) && wstrb_q[0];

  // clock selection and enable
  assign src = stc_src_t'(ctrl_q[CTRL_CS_LO +: 2]);
  assign osc_en = ctrl_q[CTRL_OSC_EN];
  assign running = ctrl_q[CTRL_ON] && (!gate_q[GATE_EN] || gate_permit); // [R2] [R14]
  assign ext.clk_in = (src == STC_SRC_CAP) ? cap_sense_oscillator :
                      (osc_en ? crystal_input_pin : external_clock_pin); // [R3]
  assign ext.sync_dis = ctrl_q[CTRL_SYNC_DIS]; // [R7] [R11]
  // re-arm on any count byte write, disable or enable
  assign ext.arm_clr = wr_lo || wr_hi || !running || (running && !on_q); // [R8]
  assign pre_mask = (3'h1 << ctrl_q[CTRL_PS_LO +: 2]) - 3'h1; // [R13]

  // source tick selection
  always_comb
  begin
    unique case (src)
      STC_SRC_SYS: tick = 1'b1; // [R5]
      STC_SRC_INSTR: tick = (idiv_q == INSTR_DIV_LAST); // [R4]
      STC_SRC_EXT: tick = ext.rise; // [R6]
      STC_SRC_CAP: tick = ext.rise; // [R6]
    endcase
  end
  assign pre_out = running && tick && ((pre_q & pre_mask) == pre_mask); // [R9]

  // counter, prescaler and instruction divider next values
  always_comb
  begin
    cnt_d = cnt_q;
    pre_d = pre_q;
    idiv_d = idiv_q + 2'h1;
    on_d = running;
    ovf_d = 1'b0;
    if (wr_lo || wr_hi)
    begin
      pre_d = 3'h0; // [R10]
      if (wr_lo)
      begin
        cnt_d[7:0] = wdata_q[7:0]; // [R1]
      end
      if (wr_hi)
      begin
        cnt_d[15:8] = wdata_q[7:0]; // [R1]
      end
    end
    else if (running && tick)
    begin
      pre_d = pre_q + 3'h1;
      if (pre_out)
      begin
        pre_d = 3'h0;
        cnt_d = cnt_q + 16'h0001; // [R1]
        ovf_d = (cnt_q == CNT_MAX); // [R12]
      end
    end
  end

  // register write and bus handshake next values
  always_comb
  begin
    ctrl_d = ctrl_q;
    gate_d = gate_q;
    awaddr_d = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awaddr_d = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_have_d = 1'b1;
    end
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (awaddr_q)
        OFF_CTRL: if (wstrb_q[0]) ctrl_d = wdata_q[7:0];
        OFF_GATE: if (wstrb_q[0]) gate_d = wdata_q[7:0];
        OFF_CNT_LO, OFF_CNT_HI: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL: rdata_d = {24'h000000, ctrl_q};
        OFF_GATE: rdata_d = {24'h000000, gate_q[7:1], ovf_q};
        OFF_CNT_LO: rdata_d = {24'h000000, cnt_q[7:0]};
        OFF_CNT_HI: rdata_d = {24'h000000, cnt_q[15:8]};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      gate_q <= GATE_RST;
      cnt_q <= CNT_RST;
      pre_q <= 3'h0;
      idiv_q <= 2'h0;
      on_q <= 1'b0;
      ovf_q <= 1'b0;
      awaddr_q <= '0;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      gate_q <= gate_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      idiv_q <= idiv_d;
      on_q <= on_d;
      ovf_q <= ovf_d;
      awaddr_q <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
endmodule : stc_timer

// ### verif/stc_timer_monitor.sv
// assertion checker for the timer core bus and overflow ports
`timescale 1ns/1ps
module stc_timer_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [stc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overflow_pulse
);
  import stc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus responses hold, readies follow pending answers
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("write response dropped");
  property p_rh;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
  endproperty
  a_rh: assert property (p_rh) else $error("read response dropped");
  property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  property p_aw; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw: assert property (p_aw) else $error("address taken twice");
  property p_bp; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_bp: assert property (p_bp) else $error("address ready with response pending");
  property p_rr; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rr: assert property (p_rr) else $error("read ready with data pending");
  property p_se;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_SLVERR;
  endproperty
  a_se: assert property (p_se) else $error("unmapped read not refused");
  // overflow is a single-cycle pulse
  property p_ov; overflow_pulse |=> !overflow_pulse; endproperty
  a_ov: assert property (p_ov) else $error("overflow pulse too long");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_se: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_ov: cover property (overflow_pulse);
endmodule : stc_timer_monitor
bind stc_timer stc_timer_monitor i_stc_timer_monitor (.*);

// ### verif/stc_clk_src.sv
// external clock source model for the timer core
`timescale 1ns/1ps
module stc_clk_src
(
  input wire logic aclk,
  input wire logic run,
  output logic clk_out
);
  logic [1:0] cnt_q;
  // half period of four aclk cycles, rests low while stopped
  always @(posedge aclk)
  begin
    cnt_q <= run ? cnt_q + 2'h1 : 2'h0;
    clk_out <= run & (clk_out ^ (cnt_q == 2'h3));
  end
endmodule : stc_clk_src

// ### verif/stc_timer_tb.sv
// self-checking bench for the timer core
`timescale 1ns/1ps
module stc_timer_tb;
  import stc_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, gate_permit = 1'h0, ext_run = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic overflow_pulse, ext_w, hit;
  logic external_clock_pin, crystal_input_pin, cap_sense_oscillator;
  logic [1:0] s_axi_bresp, s_axi_rresp, bsnap, rrsp;
  logic [1:0] sel = 2'h0;
  logic [31:0] s_axi_rdata, rsnap;
  int err_total = 0;
  int n_compared = 0;
  int n_ovf = 0;
  always #20 aclk = ~aclk;
  // model clock reaches only the selected external input
  assign external_clock_pin = ext_w & (sel == 2'h1);
  assign crystal_input_pin = ext_w & (sel == 2'h2);
  assign cap_sense_oscillator = ext_w & (sel == 2'h3);
  // overflow pulses counted where settled
  always @(negedge aclk)
    if (overflow_pulse === 1'h1)
      n_ovf++;
  stc_timer i_stc_timer (.*);
  stc_clk_src i_stc_clk_src (.aclk(aclk), .run(ext_run), .clk_out(ext_w));
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // sample at negedge, handshake completes at the next rising edge
  task automatic wt(input int k);
    hit = 1'h0;
    for (int n = 0; n < 64 && hit !== 1'h1; n++)
    begin
      @(negedge aclk);
      hit = k == 0 ? s_axi_awready & s_axi_wready : k == 1 ? s_axi_bvalid
          : k == 2 ? s_axi_arready : s_axi_rvalid;
      bsnap = s_axi_bresp;
      rsnap = s_axi_rdata;
      rrsp = s_axi_rresp;
      @(posedge aclk);
    end
    if (hit !== 1'h1)
    begin
      err_total++;
      $display("wrong value at %0t: no handshake answer", $time);
      report_and_stop();
    end
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    wt(0);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    wt(1);
    chk(bsnap, r);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    wt(2);
    s_axi_arvalid <= 1'h0;
    // late rready lets the read answer stand one cycle unanswered
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    wt(3);
    chk(rsnap, {24'h0, d});
    chk(rrsp, r);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  // load count, count for 32 cycles, stop and read both bytes
  task automatic run(input logic [7:0] c, input logic [7:0] g, input logic p,
    input logic [1:0] s, input logic [15:0] st, input logic [15:0] e);
    gate_permit <= p;
    sel <= s;
    wr(OFF_GATE, g);
    wr(OFF_CNT_LO, st[7:0]);
    wr(OFF_CNT_HI, st[15:8]);
    wr(OFF_CTRL, c | 8'h01);
    ext_run <= (s != 2'h0);
    // on from two edges into the first write to two edges into the second: 32 cycles
    repeat (20) @(posedge aclk);
    ext_run <= 1'h0;
    repeat (8) @(posedge aclk);
    wr(OFF_CTRL, c);
    rd(OFF_CNT_LO, e[7:0]);
    rd(OFF_CNT_HI, e[15:8]);
  endtask : run
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_GATE, GATE_RST);
    rd(OFF_CNT_HI, CNT_RST[15:8]);
    rd(4'h2, 8'h00, RESP_SLVERR);
    wr(4'h6, 8'hFF, RESP_SLVERR);
    run(8'h40, 8'h00, 1'h0, 2'h0, 16'h0000, 16'h0020);
    run(8'h50, 8'h00, 1'h0, 2'h0, 16'h0000, 16'h0010);
    run(8'h60, 8'h00, 1'h0, 2'h0, 16'h0000, 16'h0008);
    run(8'h70, 8'h00, 1'h0, 2'h0, 16'h0000, 16'h0004);
    run(8'h00, 8'h00, 1'h0, 2'h0, 16'h0000, 16'h0008);
    run(8'h40, 8'h80, 1'h0, 2'h0, 16'h0000, 16'h0000);
    run(8'h40, 8'h80, 1'h1, 2'h0, 16'h0000, 16'h0020);
    run(8'h80, 8'h00, 1'h0, 2'h1, 16'h0000, 16'h0002);
    run(8'h8C, 8'h00, 1'h0, 2'h2, 16'h0000, 16'h0002);
    run(8'hC4, 8'h00, 1'h0, 2'h3, 16'h0000, 16'h0002);
    run(8'h80, 8'h00, 1'h0, 2'h2, 16'h0000, 16'h0000);
    run(8'h40, 8'h00, 1'h0, 2'h0, 16'hFFF0, 16'h0010);
    chk(n_ovf, 32'h1);
    report_and_stop();
  end
endmodule : stc_timer_tb
